// *** rtl/fsgate_pkg.sv ***
package fsgate_pkg;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STAT = 8'h04;
	localparam logic [7:0] ADDR_CLR = 8'h08;
	localparam logic [7:0] ADDR_GOFF = 8'h0C;
	// Control register fields
	localparam int CTRL_ACT_LSB = 0;
	localparam int CTRL_CUM_LSB = 4;
	localparam int CTRL_ALMSEL_LSB = 8;
	localparam int CTRL_ALMFILT = 12;
	localparam int CTRL_RELAYOPT = 13;
	localparam int CTRL_PUMPEN = 14;
	localparam logic [31:0] CTRL_RESET = 32'h0000_6F01;
	// Status and clear bit positions
	localparam int ST_UNDER = 0;
	localparam int ST_OVER = 1;
	localparam int ST_ANSERR = 2;
	localparam int ST_TIMEOUT = 3;
	localparam int ST_CUMERR = 4;
	localparam int ST_ALARM = 5;
	localparam int ST_LBFAIL = 6;
	localparam int ST_ABFAIL = 7;
	localparam int ST_READY = 8;
	localparam logic [2:0] ACT_OFF = 3'h0;
	localparam logic [2:0] ACT_PHREL = 3'h2;
	localparam logic [2:0] ACT_PHASE = 3'h3;
	localparam logic [2:0] ACT_ALL = 3'h4;
	localparam logic [2:0] ACT_LATCH = 3'h5;
	localparam logic [1:0] CUM_FLAG = 2'h0;
	localparam logic [1:0] CUM_PHASE = 2'h1;
	localparam logic [1:0] CUM_PHREL = 2'h2;
	localparam logic [1:0] CUM_ALL = 2'h3;
	localparam int CLK_MHZ = 125;
	localparam int TEST_MAX_US = 4000;
	localparam int TEST_MAX_CYC = TEST_MAX_US * CLK_MHZ;
	localparam int WINDOW_CYC = 256;
	localparam int ALM_FILT_CYC = 8;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;

	typedef struct packed {
		logic phase_u;
		logic phase_v;
		logic phase_w;
		logic relay;
	} fsgate_gates_s;

	typedef enum logic [3:0] {
		ST_WAIT = 4'b0001,
		ST_LOGIC = 4'b0010,
		ST_ANALOG = 4'b0100,
		ST_RUN = 4'b1000
	} fsgate_seq_e;
endpackage : fsgate_pkg

// *** rtl/fsgate_top.sv ***
`timescale 1ns/1ps
module fsgate_top #(
	parameter int LOGIC_TEST_CYC = 1000,
	parameter int ANALOG_TEST_CYC = 2000,
	parameter int CNT_W = 12,
	// Band around 128 edges: the synchroniser sees at most one per clock,
	// so a nominal rate near that ceiling could never show overspeed
	parameter logic [11:0] LIMIT_LO = 12'h073,
	parameter logic [11:0] LIMIT_HI = 12'h08D
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// Interface oscillator tick, asynchronous
	input wire logic i_if_osc,
	// Analog and test status
	input wire logic i_uv_released,
	input wire logic i_logic_pass,
	input wire logic i_analog_fault,
	input wire logic i_other_fault,
	// Query response check events, same clock
	input wire logic i_answer_err,
	input wire logic i_answer_timeout,
	input wire logic i_cumulative_err,
	// Alarm pin, active low
	input wire logic i_alarm_n,
	// AXI4-Lite write
	input wire logic [7:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	// AXI4-Lite read
	input wire logic [7:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	// Outputs
	output fsgate_pkg::fsgate_gates_s o_gate_en,
	output logic o_pump_run_internal,
	output logic o_diag_out_n,
	output logic o_analog_toggle
);
	import fsgate_pkg::*;

	if (LIMIT_LO >= LIMIT_HI || LIMIT_HI > 12'(WINDOW_CYC - 1) || CNT_W < 9
		|| LOGIC_TEST_CYC < 1 || ANALOG_TEST_CYC < 1
		|| LOGIC_TEST_CYC + ANALOG_TEST_CYC > TEST_MAX_CYC) begin : g_bad_param
		$error("fsgate_top: bad parameters");
	end

	////////////////////////////////////////////////////////////////////
	// Registers and synchronisers
	logic [31:0] ctrl_ff;
	logic [2:0] act_live_ff;
	logic [4:0] flags_ff;
	fsgate_gates_s goff_ff;
	logic [2:0] osc_sync_ff;
	logic [1:0] alm_sync_ff;
	logic [3:0] alm_filt_ff;
	logic alarm_ff;
	fsgate_seq_e seq_ff;
	logic [19:0] seq_cnt_ff;
	logic lb_fail_ff;
	logic ab_fail_ff;
	logic [CNT_W-1:0] if_cnt_ff;
	logic [7:0] win_ff;
	logic under_now_ff;
	logic over_now_ff;
	logic [2:0] act_req;
	logic [1:0] cum_act;
	logic freq_bad;
	logic any_freq_flag;
	logic in_test;

	assign act_req = ctrl_ff[CTRL_ACT_LSB +: 3];
	assign cum_act = ctrl_ff[CTRL_CUM_LSB +: 2];
	assign freq_bad = under_now_ff | over_now_ff;
	assign any_freq_flag = flags_ff[ST_UNDER] | flags_ff[ST_OVER];
	assign in_test = (seq_ff != ST_RUN);

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			osc_sync_ff <= 3'h0;
			alm_sync_ff <= 2'h3;
		end else begin
			osc_sync_ff <= {osc_sync_ff[1:0], i_if_osc};
			alm_sync_ff <= {alm_sync_ff[0], i_alarm_n};
		end
	end

	////////////////////////////////////////////////////////////////////
	// Start-up sequence
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			seq_ff <= ST_WAIT;
			seq_cnt_ff <= 20'h0;
			lb_fail_ff <= 1'b0;
			ab_fail_ff <= 1'b0;
			o_analog_toggle <= 1'b0;
		end else begin
			seq_cnt_ff <= seq_cnt_ff + 20'h1;
			unique case (seq_ff)
				ST_WAIT: begin
					seq_cnt_ff <= 20'h0;
					if (i_uv_released) begin
						seq_ff <= ST_LOGIC;
					end
				end
				ST_LOGIC: begin
					if (seq_cnt_ff == 20'(LOGIC_TEST_CYC - 1)) begin
						seq_cnt_ff <= 20'h0;
						if (i_logic_pass) begin
							seq_ff <= ST_ANALOG;
						end else begin
							lb_fail_ff <= 1'b1;
							seq_ff <= ST_RUN;
						end
					end
				end
				ST_ANALOG: begin
					o_analog_toggle <= ~o_analog_toggle;
					if (i_analog_fault) begin
						ab_fail_ff <= 1'b1;
					end
					if (seq_cnt_ff == 20'(ANALOG_TEST_CYC - 1)) begin
						seq_ff <= ST_RUN;
						o_analog_toggle <= 1'b0;
					end
				end
				ST_RUN: begin
					seq_cnt_ff <= 20'h0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Frequency cross-check: count interface edges per window
	always_ff @(posedge i_clk) begin
		if (i_reset || in_test) begin
			if_cnt_ff <= '0;
			win_ff <= 8'h0;
			under_now_ff <= 1'b0;
			over_now_ff <= 1'b0;
		end else begin
			win_ff <= win_ff + 8'h1;
			if (win_ff == 8'(WINDOW_CYC - 1)) begin
				if_cnt_ff <= '0;
				under_now_ff <= (if_cnt_ff <= LIMIT_LO);
				over_now_ff <= (if_cnt_ff >= LIMIT_HI);
			end else if (osc_sync_ff[2] != osc_sync_ff[1]) begin
				if_cnt_ff <= if_cnt_ff + 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Alarm filter; sampled on this clock, the reported domain
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			alm_filt_ff <= 4'h0;
			alarm_ff <= 1'b0;
		end else if (!ctrl_ff[CTRL_ALMFILT]) begin
			alm_filt_ff <= 4'h0;
			alarm_ff <= ~alm_sync_ff[1];
		end else if (~alm_sync_ff[1] != alarm_ff) begin
			alm_filt_ff <= alm_filt_ff + 4'h1;
			if (alm_filt_ff == 4'(ALM_FILT_CYC - 1)) begin
				alarm_ff <= ~alarm_ff;
				alm_filt_ff <= 4'h0;
			end
		end else begin
			alm_filt_ff <= 4'h0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Status flags: set wins over clear
	logic wr_go;
	logic [7:0] wr_addr_ff;
	logic [31:0] wr_data_ff;
	logic aw_have_ff;
	logic w_have_ff;
	logic clr_req;
	assign wr_go = aw_have_ff & w_have_ff & ~o_bvalid;
	assign clr_req = wr_go && wr_addr_ff == ADDR_CLR;

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			flags_ff <= 5'h0;
		end else begin
			if (clr_req) begin
				flags_ff[ST_ANSERR] <= flags_ff[ST_ANSERR]
					& ~wr_data_ff[ST_ANSERR];
				flags_ff[ST_TIMEOUT] <= flags_ff[ST_TIMEOUT]
					& ~wr_data_ff[ST_TIMEOUT];
				flags_ff[ST_CUMERR] <= flags_ff[ST_CUMERR]
					& ~wr_data_ff[ST_CUMERR];
				if (!freq_bad) begin
					flags_ff[ST_UNDER] <= flags_ff[ST_UNDER]
						& ~wr_data_ff[ST_UNDER];
					flags_ff[ST_OVER] <= flags_ff[ST_OVER]
						& ~wr_data_ff[ST_OVER];
				end
			end
			if (act_live_ff != ACT_OFF && !in_test) begin
				if (under_now_ff) flags_ff[ST_UNDER] <= 1'b1;
				if (over_now_ff) flags_ff[ST_OVER] <= 1'b1;
			end
			if (i_answer_err) flags_ff[ST_ANSERR] <= 1'b1;
			if (i_answer_timeout) flags_ff[ST_TIMEOUT] <= 1'b1;
			if (i_cumulative_err) flags_ff[ST_CUMERR] <= 1'b1;
		end
	end

	// Stored action applies once error is gone and both flags clear
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			act_live_ff <= CTRL_RESET[CTRL_ACT_LSB +: 3];
		end else if (!freq_bad && !any_freq_flag) begin
			act_live_ff <= act_req;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Gate-off and enable composition
	logic ph_off;
	logic rl_off;
	logic cp_off;
	logic fa;
	assign fa = freq_bad && act_live_ff != ACT_OFF;
	always_comb begin
		ph_off = in_test || lb_fail_ff || ab_fail_ff;
		rl_off = ph_off;
		cp_off = ph_off || i_other_fault;
		if (fa && act_live_ff == ACT_PHREL) begin
			ph_off = 1'b1;
			rl_off = 1'b1;
		end
		if (fa && act_live_ff == ACT_PHASE) ph_off = 1'b1;
		if ((fa && act_live_ff == ACT_ALL)
			|| (act_live_ff == ACT_LATCH && any_freq_flag)) begin
			ph_off = 1'b1;
			rl_off = 1'b1;
			cp_off = 1'b1;
		end
		if (flags_ff[ST_CUMERR]) begin
			if (cum_act != CUM_FLAG) ph_off = 1'b1;
			if (cum_act == CUM_PHREL || cum_act == CUM_ALL) rl_off = 1'b1;
			if (cum_act == CUM_ALL) cp_off = 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_gate_en <= '0;
			o_pump_run_internal <= 1'b0;
			o_diag_out_n <= 1'b0;
		end else begin
			o_gate_en.phase_u <= ~(ph_off | goff_ff.phase_u)
				& ~(alarm_ff & ctrl_ff[CTRL_ALMSEL_LSB]);
			o_gate_en.phase_v <= ~(ph_off | goff_ff.phase_v)
				& ~(alarm_ff & ctrl_ff[CTRL_ALMSEL_LSB + 1]);
			o_gate_en.phase_w <= ~(ph_off | goff_ff.phase_w)
				& ~(alarm_ff & ctrl_ff[CTRL_ALMSEL_LSB + 2]);
			o_gate_en.relay <= ~(rl_off | goff_ff.relay)
				& ~(alarm_ff & ctrl_ff[CTRL_RELAYOPT]
				& ctrl_ff[CTRL_ALMSEL_LSB + 3]);
			o_pump_run_internal <= ~cp_off & ctrl_ff[CTRL_PUMPEN];
			o_diag_out_n <= ~(in_test || lb_fail_ff || ab_fail_ff
				|| |flags_ff[ST_CUMERR:ST_UNDER]);
		end
	end

	////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave: one write and one read at a time
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			aw_have_ff <= 1'b0;
			w_have_ff <= 1'b0;
			wr_addr_ff <= 8'h0;
			wr_data_ff <= 32'h0;
			o_bvalid <= 1'b0;
			o_bresp <= AXI_OKAY;
		end else begin
			if (i_awvalid && o_awready) begin
				aw_have_ff <= 1'b1;
				wr_addr_ff <= i_awaddr;
			end
			if (i_wvalid && o_wready) begin
				w_have_ff <= 1'b1;
				wr_data_ff <= i_wdata;
			end
			if (wr_go) begin
				aw_have_ff <= 1'b0;
				w_have_ff <= 1'b0;
				o_bvalid <= 1'b1;
				o_bresp <= (wr_addr_ff == ADDR_CTRL || wr_addr_ff == ADDR_CLR
					|| wr_addr_ff == ADDR_GOFF) ? AXI_OKAY : AXI_SLVERR;
			end else if (o_bvalid && i_bready) begin
				o_bvalid <= 1'b0;
			end
		end
	end
	assign o_awready = ~aw_have_ff & ~o_bvalid;
	assign o_wready = ~w_have_ff & ~o_bvalid;

	// Byte strobes honoured on control and gate-off registers
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			ctrl_ff <= CTRL_RESET;
			goff_ff <= '0;
		end else if (wr_go && wr_addr_ff == ADDR_CTRL) begin
			for (int b = 0; b < 2; b++) begin
				if (i_wstrb[b]) ctrl_ff[b*8 +: 8] <= wr_data_ff[b*8 +: 8];
			end
		end else if (wr_go && wr_addr_ff == ADDR_GOFF && i_wstrb[0]) begin
			goff_ff <= wr_data_ff[3:0];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_rvalid <= 1'b0;
			o_rdata <= 32'h0;
			o_rresp <= AXI_OKAY;
		end else if (i_arvalid && o_arready) begin
			o_rvalid <= 1'b1;
			o_rresp <= AXI_OKAY;
			unique case (i_araddr)
				ADDR_CTRL: o_rdata <= {17'h0, ctrl_ff[14:0]};
				ADDR_STAT: o_rdata <= {23'h0, seq_ff == ST_RUN, ab_fail_ff,
					lb_fail_ff, alarm_ff, flags_ff[4:0]};
				ADDR_GOFF: o_rdata <= {28'h0, goff_ff};
				default: begin
					o_rdata <= 32'h0;
					o_rresp <= AXI_SLVERR;
				end
			endcase
		end else if (o_rvalid && i_rready) begin
			o_rvalid <= 1'b0;
		end
	end
	assign o_arready = ~o_rvalid;
endmodule : fsgate_top

// *** tb/fsgate_monitor.sv ***
`timescale 1ns/1ps
module fsgate_monitor
	import fsgate_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// Stimulus seen
	input wire logic i_other_fault,
	input wire logic i_awvalid,
	input wire logic i_wvalid,
	input wire logic i_bready,
	input wire logic i_arvalid,
	input wire logic i_rready,
	// Design outputs
	input wire logic o_awready,
	input wire logic o_wready,
	input wire logic [1:0] o_bresp,
	input wire logic o_bvalid,
	input wire logic o_arready,
	input wire logic [31:0] o_rdata,
	input wire logic o_rvalid,
	input wire fsgate_gates_s o_gate_en,
	input wire logic o_pump_run_internal,
	input wire logic o_diag_out_n,
	input wire logic o_analog_toggle
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	sequence s_write_taken;
		i_awvalid && o_awready && i_wvalid && o_wready;
	endsequence
	sequence s_test_step;
		$changed(o_analog_toggle);
	endsequence
	a_reset_all_off: assert property (disable iff (1'b0)
		i_reset |=> o_gate_en == '0 && !o_pump_run_internal)
		else $error("drivers on during reset");
	a_pump_fault_off: assert property (
		i_other_fault |=> !o_pump_run_internal)
		else $error("pump runs with a fault present");
	a_test_diag_low: assert property (s_test_step |-> !o_diag_out_n)
		else $error("diag high during analog test");
	a_test_drivers_off: assert property (
		s_test_step |-> o_gate_en == '0 && !o_pump_run_internal)
		else $error("drivers on during analog test");
	a_write_answer: assert property (s_write_taken |-> ##2 o_bvalid)
		else $error("write response late");
	a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
		else $error("read response late");
	a_bresp_hold: assert property (
		o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
		else $error("write response dropped");
	a_rdata_hold: assert property (
		o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
		else $error("read data dropped");
endmodule : fsgate_monitor
////////////////////////////////////////////////////////////////////////
bind fsgate_top fsgate_monitor i_mon (.i_clk(i_clk), .i_reset(i_reset),
	.i_other_fault(i_other_fault), .i_awvalid(i_awvalid),
	.i_wvalid(i_wvalid), .i_bready(i_bready), .i_arvalid(i_arvalid),
	.i_rready(i_rready), .o_awready(o_awready), .o_wready(o_wready),
	.o_bresp(o_bresp), .o_bvalid(o_bvalid), .o_arready(o_arready),
	.o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_gate_en(o_gate_en),
	.o_pump_run_internal(o_pump_run_internal),
	.o_diag_out_n(o_diag_out_n), .o_analog_toggle(o_analog_toggle));

// *** tb/fsgate_mcu.sv ***
`timescale 1ns/1ps
module fsgate_mcu #(
	parameter int WAIT_CYC = 40
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// Requests from the bench
	input wire logic i_uv_released,
	input wire logic i_alarm_req,
	// Pin and bus permission
	output logic o_alarm_n,
	output logic o_host_ok
);
	int cnt_ff;
	// Scaled stand-in for the worst-case self test time
	always_ff @(posedge i_clk) begin
		if (i_reset || !i_uv_released) begin
			cnt_ff <= 0;
		end else if (cnt_ff < WAIT_CYC) begin
			cnt_ff <= cnt_ff + 1;
		end
	end
	assign o_host_ok = (cnt_ff == WAIT_CYC);
	always_ff @(posedge i_clk) begin
		o_alarm_n <= !i_alarm_req;
	end
endmodule : fsgate_mcu

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench;
	import fsgate_pkg::*;
	logic i_clk = '0, i_reset = '1, i_if_osc = '0, i_uv_released = '0;
	logic i_logic_pass = '1, i_analog_fault = '0, i_other_fault = '0;
	logic alarm_req = '0, i_alarm_n, host_ok;
	logic [2:0] evt = '0;
	logic [7:0] i_awaddr = '0, i_araddr = '0;
	logic [31:0] i_wdata = '0, o_rdata;
	logic [3:0] i_wstrb = 4'hF;
	logic i_awvalid = '0, i_wvalid = '0, i_bready = '0;
	logic i_arvalid = '0, i_rready = '0;
	logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
	logic o_pump_run_internal, o_diag_out_n, o_analog_toggle;
	logic [1:0] o_bresp, o_rresp;
	fsgate_gates_s o_gate_en;
	wire i_answer_err = evt[0];
	wire i_answer_timeout = evt[1];
	wire i_cumulative_err = evt[2];
	int miscompares = 0, compares = 0, cycles = 0;
	// Nominal interface rate: a quarter of the clock, 128 edges a window
	real half = 16.0;
	fsgate_top #(.LOGIC_TEST_CYC(5), .ANALOG_TEST_CYC(8)) i_dut (
		.i_clk(i_clk), .i_reset(i_reset), .i_if_osc(i_if_osc),
		.i_uv_released(i_uv_released), .i_logic_pass(i_logic_pass),
		.i_analog_fault(i_analog_fault), .i_other_fault(i_other_fault),
		.i_answer_err(i_answer_err), .i_answer_timeout(i_answer_timeout),
		.i_cumulative_err(i_cumulative_err), .i_alarm_n(i_alarm_n),
		.i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
		.i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid),
		.o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
		.i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
		.o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp),
		.o_rvalid(o_rvalid), .i_rready(i_rready), .o_gate_en(o_gate_en),
		.o_pump_run_internal(o_pump_run_internal),
		.o_diag_out_n(o_diag_out_n), .o_analog_toggle(o_analog_toggle));
	fsgate_mcu #(.WAIT_CYC(40)) i_mcu (.i_clk(i_clk), .i_reset(i_reset),
		.i_uv_released(i_uv_released), .i_alarm_req(alarm_req),
		.o_alarm_n(i_alarm_n), .o_host_ok(host_ok));
	initial forever #4 i_clk = ~i_clk;
	// Odd offset keeps every oscillator edge off a clock edge
	initial begin
		#3;
		forever #(half) i_if_osc = ~i_if_osc;
	end
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 30000) begin
			miscompares++;
			print_verdict();
		end
	end
	////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		if (miscompares == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : print_verdict
	task automatic chk(input string nm, input logic [31:0] s, e);
		compares++;
		if (s !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
	endtask : tick
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic aw_ok, w_ok;
		aw_ok = 0;
		w_ok = 0;
		i_awaddr <= a;
		i_wdata <= d;
		i_awvalid <= '1;
		i_wvalid <= '1;
		while (!(aw_ok && w_ok)) begin
			@(posedge i_clk);
			if (i_awvalid && o_awready === 1'b1) begin
				aw_ok = 1;
				i_awvalid <= '0;
			end
			if (i_wvalid && o_wready === 1'b1) begin
				w_ok = 1;
				i_wvalid <= '0;
			end
		end
		while (o_bvalid !== 1'b1) @(posedge i_clk);
		i_bready <= '1;
		@(posedge i_clk);
		chk("bresp", o_bresp, er);
		i_bready <= '0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er = AXI_OKAY);
		i_araddr <= a;
		i_arvalid <= '1;
		do @(posedge i_clk); while (o_arready !== 1'b1);
		i_arvalid <= '0;
		do @(posedge i_clk); while (o_rvalid !== 1'b1);
		i_rready <= '1;
		@(posedge i_clk);
		chk("rdata", o_rdata, e);
		chk("rresp", o_rresp, er);
		i_rready <= '0;
	endtask : rd
	task automatic outs(input logic [3:0] g, input logic p, input logic d);
		chk("gates", o_gate_en, g);
		chk("pump", o_pump_run_internal, p);
		chk("diag", o_diag_out_n, d);
	endtask : outs
	////////////////////////////////////////////////////////////////////
	task automatic t_startup();
		outs(4'h0, 0, 0);
		i_uv_released <= '1;
		while (host_ok !== 1'b1) @(posedge i_clk);
		outs(4'hF, 1, 1);
		rd(ADDR_CTRL, CTRL_RESET);
		rd(ADDR_STAT, 32'h100);
		wr(8'h10, 32'h0, AXI_SLVERR);
		rd(ADDR_CLR, 32'h0, AXI_SLVERR);
	endtask : t_startup
	task automatic t_freq();
		logic [4:0] eo;
		logic [31:0] st;
		for (int a = 0; a < 6; a++) begin
			if (a == 1) continue;
			eo = (a == 2) ? 5'h01 : (a == 3) ? 5'h03 : (a == 0) ? 5'h1F : 5'h0;
			st = (a == 4) ? 32'h102 : 32'h101;
			wr(ADDR_CTRL, {CTRL_RESET[31:3], 3'(a)}, AXI_OKAY);
			half = (a == 4) ? 10.0 : 32.0;
			tick(600);
			outs(eo[4:1], eo[0], a == 0);
			rd(ADDR_STAT, a == 0 ? 32'h100 : st);
			if (a == 0) begin
				half = 16.0;
				tick(600);
				continue;
			end
			if (a == 2) begin
				wr(ADDR_CTRL, {CTRL_RESET[31:3], 3'h3}, AXI_OKAY);
				tick(2);
				chk("gates", o_gate_en, 4'h0);
				rd(ADDR_CTRL, 32'h6F03);
			end
			wr(ADDR_CLR, 32'h3, AXI_OKAY);
			rd(ADDR_STAT, st);
			half = 16.0;
			tick(600);
			outs(a == 5 ? 4'h0 : 4'hF, a != 5, 0);
			wr(ADDR_CLR, 32'h3, AXI_OKAY);
			tick(4);
			outs(4'hF, 1, 1);
		end
	endtask : t_freq
	task automatic t_events();
		wr(ADDR_CTRL, CTRL_RESET | 32'h20, AXI_OKAY);
		for (int i = 0; i < 3; i++) begin
			evt <= 3'(1 << i);
			tick(1);
			evt <= '0;
			tick(3);
			outs(i == 2 ? 4'h0 : 4'hF, 1, 0);
			rd(ADDR_STAT, 32'h100 | (32'h4 << i));
			wr(ADDR_CLR, 32'h4 << i, AXI_OKAY);
			tick(3);
			outs(4'hF, 1, 1);
		end
		for (int c = 0; c < 4; c++) begin
			wr(ADDR_CTRL, CTRL_RESET | (32'(c) << 4), AXI_OKAY);
			evt <= 3'h4;
			tick(1);
			evt <= '0;
			tick(3);
			outs(c == 0 ? 4'hF : c == 1 ? 4'h1 : 4'h0, c != 3, 0);
			wr(ADDR_CLR, 32'h10, AXI_OKAY);
			tick(3);
		end
	endtask : t_events
	task automatic t_alarm();
		alarm_req <= '1;
		tick(10);
		chk("gates", o_gate_en, 4'h0);
		rd(ADDR_STAT, 32'h120);
		alarm_req <= '0;
		tick(10);
		wr(ADDR_GOFF, 32'h5, AXI_OKAY);
		tick(3);
		chk("gates", o_gate_en, 4'hA);
		wr(ADDR_GOFF, 32'h0, AXI_OKAY);
		i_other_fault <= '1;
		tick(3);
		chk("pump", o_pump_run_internal, 1'b0);
		i_other_fault <= '0;
		tick(3);
		outs(4'hF, 1, 1);
		wr(ADDR_CTRL, 32'h5F31, AXI_OKAY);
		alarm_req <= '1;
		tick(4);
		chk("gates", o_gate_en, 4'hF);
		tick(10);
		chk("gates", o_gate_en, 4'h1);
		alarm_req <= '0;
		tick(14);
		chk("gates", o_gate_en, 4'hF);
		i_wstrb <= 4'h2;
		wr(ADDR_CTRL, 32'h2F00, AXI_OKAY);
		i_wstrb <= 4'hF;
		rd(ADDR_CTRL, 32'h2F31);
		chk("pump", o_pump_run_internal, 1'b0);
	endtask : t_alarm
	task automatic t_logic_fail();
		for (int k = 0; k < 2; k++) begin
			i_reset <= '1;
			i_logic_pass <= (k == 1);
			i_analog_fault <= (k == 1);
			tick(3);
			i_reset <= '0;
			tick(60);
			outs(4'h0, 0, 0);
			rd(ADDR_STAT, k == 0 ? 32'h140 : 32'h180);
		end
	endtask : t_logic_fail
	initial begin
		tick(3);
		i_reset <= '0;
		tick(2);
		t_startup();
		t_freq();
		t_events();
		t_alarm();
		t_logic_fail();
		print_verdict();
	end
endmodule : testbench
